// file: banked_register_file_psr.sv
// Mode-banked register file with one current and four saved status words.
// Notes on behaviour
// - Instructions are four bytes wide, two compact.
// - Halfwords and words must be naturally aligned.
// - Twenty-nine general and five status registers stored.
// - Sixteen visible registers; exception modes swap banks.
// - Branch with link copies counter into r14.
// - Counter low bits forced zero per state.
// - Fast-interrupt mode banks registers eight to fourteen.
// - Other exception modes bank r13 and r14.
// - System mode uses user bank, no saved word.
// - Compact low registers, pointers, status words shared.
// - Compact high registers need special instruction variants.
// - One current, four saved status words.
// - Flags set by operations, tested as conditions.
// - Compact state conditions only branches.
// - Control byte changes on exception, privileged writes.
// - State bit set selects compact state.
// - Mask bits block normal and fast interrupts.
// - Mode codes decode to their register sets.
// - Illegal mode code locks until reset.
// - Software never writes the state bit; a saved-word write can set it, and a return loads it.
// - Software preserves reserved bits of status words.
// - No abort mode, bank or saved word.
// - Reset forces supervisor mode, both masks set.
`include "rf_consts.svh"
module banked_register_file_psr (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Datapath connection.
  rf_if.regfile core,
  // Interrupt gating and fault.
  output logic irq_blocked,
  output logic fiq_blocked,
  output logic unrecoverable
);
  import rf_pkg::*;

  rf_state_s st_r;
  rf_state_s st_nxt;
  logic [4:0] mode;
  logic compact;
  logic locked_now;
  logic [4:0] a_phys;
  logic [4:0] b_phys;
  logic [4:0] wr_phys;
  logic [4:0] link_phys;
  logic [4:0] ent_link_phys;
  logic [1:0] slot;
  logic [1:0] ent_slot;
  logic refused;

  function automatic logic mode_legal(input logic [4:0] m);
    return m == `MODE_USR || m == `MODE_FIQ || m == `MODE_IRQ || m == `MODE_SVC || m == `MODE_UND ||
           m == `MODE_SYS;
  endfunction : mode_legal

  // No abort mode exists, so only four modes own a saved word.
  function automatic logic has_saved(input logic [4:0] m);
    return m == `MODE_FIQ || m == `MODE_IRQ || m == `MODE_SVC || m == `MODE_UND;
  endfunction : has_saved

  function automatic logic [1:0] saved_slot(input logic [4:0] m);
    case (m)
      `MODE_IRQ: return `SLOT_IRQ;
      `MODE_SVC: return `SLOT_SVC;
      `MODE_UND: return `SLOT_UND;
      default: return `SLOT_FIQ;
    endcase
  endfunction : saved_slot

  // Maps a visible index to its physical slot for the given mode.
  function automatic logic [4:0] map_reg(input logic [4:0] m, input logic [3:0] r);
    logic [4:0] base;
    base = 5'h00;
    if (r == `PC_IDX) begin
      return `PH_PC;
    end
    if (r < `HI_BASE) begin
      return {1'b0, r};
    end
    case (m)
      `MODE_FIQ: return `PH_FIQ + {1'b0, r - `HI_BASE};
      `MODE_IRQ: base = `PH_IRQ;
      `MODE_SVC: base = `PH_SVC;
      `MODE_UND: base = `PH_UND;
      default: return {1'b0, r};
    endcase
    return (r >= `STACK_IDX) ? base + {1'b0, r - `STACK_IDX} : {1'b0, r};
  endfunction : map_reg

  function automatic logic [31:0] pc_align(input logic [31:0] d, input logic cpt);
    return cpt ? {d[31:1], 1'b0} : {d[31:2], 2'b00};
  endfunction : pc_align

  // Registers 8 to 12 are hidden in compact state unless the datapath flags a special variant.
  function automatic logic hi_hidden(input logic [3:0] r, input logic cpt, input logic ok);
    return cpt && !ok && r >= `HI_BASE && r < `STACK_IDX;
  endfunction : hi_hidden

  function automatic logic cond_eval(input logic [3:0] c, input logic [31:0] s);
    logic n;
    logic z;
    logic cy;
    logic v;
    n = s[`SW_N];
    z = s[`SW_Z];
    cy = s[`SW_C];
    v = s[`SW_V];
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return cy;
      4'h3: return !cy;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return cy && !z;
      4'h9: return !cy || z;
      4'hA: return n == v;
      4'hB: return n != v;
      4'hC: return !z && n == v;
      4'hD: return z || n != v;
      default: return 1'b1;
    endcase
  endfunction : cond_eval

  assign mode = st_r.cur[`SW_M_HI:0];
  assign compact = st_r.cur[`SW_T];
  assign locked_now = st_r.locked || !mode_legal(mode);
  assign a_phys = map_reg(mode, core.rd_a_idx);
  assign b_phys = map_reg(mode, core.rd_b_idx);
  assign wr_phys = map_reg(mode, core.wr_idx);
  assign link_phys = map_reg(mode, `LINK_IDX);
  assign ent_link_phys = map_reg(core.enter_mode, `LINK_IDX);
  assign slot = saved_slot(mode);
  assign ent_slot = saved_slot(core.enter_mode);

  always_comb begin
    refused = 1'b0;
    if (core.op != OP_NONE && locked_now) begin
      refused = 1'b1;
    end else begin
      case (core.op)
        OP_WRITE: refused = hi_hidden(core.wr_idx, compact, core.hi_ok);
        OP_CTRL: refused = mode == `MODE_USR;
        OP_SAVED_RD, OP_SAVED_WR, OP_RETURN: refused = !has_saved(mode);
        OP_ENTER: refused = !has_saved(core.enter_mode);
        default: refused = 1'b0;
      endcase
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.locked = locked_now;
    if (!refused) begin
      case (core.op)
        OP_WRITE: begin
          if (core.wr_idx == `PC_IDX) begin
            st_nxt.gpr[`PH_PC] = pc_align(core.wr_data, compact);
          end else begin
            st_nxt.gpr[wr_phys] = core.wr_data;
          end
        end
        OP_PC: st_nxt.gpr[`PH_PC] = pc_align(core.wr_data, compact);
        OP_LINK: begin
          st_nxt.gpr[link_phys] = st_r.gpr[`PH_PC];
          st_nxt.gpr[`PH_PC] = pc_align(core.wr_data, compact);
        end
        OP_FLAGS: st_nxt.cur = (st_r.cur & ~`SW_FLAGS) | (core.wr_data & `SW_FLAGS);
        OP_CTRL: begin
          st_nxt.cur = (st_r.cur & `SW_FLAGS) | (core.wr_data & `SW_KEEP & ~`SW_FLAGS);
          st_nxt.cur[`SW_T] = st_r.cur[`SW_T];
        end
        OP_ENTER: begin
          st_nxt.saved[ent_slot] = st_r.cur;
          st_nxt.cur[`SW_M_HI:0] = core.enter_mode;
          st_nxt.cur[`SW_T] = 1'b0;
          st_nxt.cur[`SW_I] = 1'b1;
          if (core.enter_mode == `MODE_FIQ) begin
            st_nxt.cur[`SW_F] = 1'b1;
          end
          st_nxt.gpr[ent_link_phys] = core.wr_data;
        end
        OP_RETURN: begin
          st_nxt.cur = st_r.saved[slot];
          st_nxt.gpr[`PH_PC] = pc_align(core.wr_data, st_r.saved[slot][`SW_T]);
        end
        OP_SAVED_WR: st_nxt.saved[slot] = core.wr_data & `SW_KEEP;
        default: st_nxt.locked = locked_now;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.cur <= `SW_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign core.rd_a_data = hi_hidden(core.rd_a_idx, compact, core.hi_ok) ? 32'h0000_0000 : st_r.gpr[a_phys];
  assign core.rd_b_data = hi_hidden(core.rd_b_idx, compact, core.hi_ok) ? 32'h0000_0000 : st_r.gpr[b_phys];
  assign core.saved_data = has_saved(mode) ? st_r.saved[slot] : 32'h0000_0000;
  assign core.status_word = st_r.cur;
  assign core.cond_pass = (compact && !core.is_branch) ? 1'b1 : cond_eval(core.cond, st_r.cur);
  assign core.compact = compact;
  assign core.insn_bytes = compact ? `LEN_COMPACT : `LEN_WIDE;
  assign core.misaligned = (core.acc_size == `ACC_HALF && core.acc_addr[0]) ||
                           (core.acc_size == `ACC_WORD && core.acc_addr != 2'h0);
  assign core.refused = refused;
  assign core.privileged = mode != `MODE_USR;
  assign irq_blocked = st_r.cur[`SW_I];
  assign fiq_blocked = st_r.cur[`SW_F];
  assign unrecoverable = locked_now;
endmodule : banked_register_file_psr

// file: rf_consts.svh
// Constants shared by the banked register file and its datapath end.
`ifndef RF_CONSTS_SVH
`define RF_CONSTS_SVH
`define MODE_USR 5'h10
`define MODE_FIQ 5'h11
`define MODE_IRQ 5'h12
`define MODE_SVC 5'h13
`define MODE_UND 5'h1B
`define MODE_SYS 5'h1F
`define SW_N 31
`define SW_Z 30
`define SW_C 29
`define SW_V 28
`define SW_I 7
`define SW_F 6
`define SW_T 5
`define SW_M_HI 4
`define SW_KEEP 32'hF00000FF
`define SW_FLAGS 32'hF0000000
`define SW_RESET 32'h000000D3
`define NUM_PHYS 29
`define NUM_SAVED 4
`define STACK_IDX 4'hD
`define LINK_IDX 4'hE
`define PC_IDX 4'hF
`define HI_BASE 4'h8
`define PH_PC 5'h0F
`define PH_FIQ 5'h10
`define PH_IRQ 5'h17
`define PH_SVC 5'h19
`define PH_UND 5'h1B
`define SLOT_FIQ 2'h0
`define SLOT_IRQ 2'h1
`define SLOT_SVC 2'h2
`define SLOT_UND 2'h3
`define ACC_HALF 2'h1
`define ACC_WORD 2'h2
`define LEN_WIDE 3'h4
`define LEN_COMPACT 3'h2
`define OFS_CMD 5'h00
`define OFS_WDATA 5'h04
`define OFS_RESULT 5'h08
`define OFS_FLAGS 5'h0C
`define OFS_STATUS 5'h10
`endif

// file: rf_pkg.sv
// Types shared by the register file, its interface and the datapath end.
`include "rf_consts.svh"
package rf_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_WRITE, OP_PC, OP_LINK, OP_FLAGS, OP_CTRL,
    OP_ENTER, OP_RETURN, OP_SAVED_RD, OP_SAVED_WR, OP_COND
  } op_e;
  typedef struct packed {
    logic [`NUM_PHYS-1:0][31:0] gpr;
    logic [31:0] cur;
    logic [`NUM_SAVED-1:0][31:0] saved;
    logic locked;
  } rf_state_s;
  typedef struct packed {
    logic ack;
    logic [31:0] readdata;
    logic [31:0] cmd;
    logic [31:0] wdata;
    logic [31:0] result;
    logic [3:0] last;
    logic issued;
    op_e op;
    logic [31:0] wr_data;
  } dp_state_s;
endpackage : rf_pkg

// file: rf_if.sv
// Connection between the core datapath and the banked register file.
interface rf_if;
  import rf_pkg::*;
  op_e op;
  logic [3:0] rd_a_idx;
  logic [3:0] rd_b_idx;
  logic [3:0] wr_idx;
  logic [31:0] wr_data;
  logic hi_ok;
  logic is_branch;
  logic [3:0] cond;
  logic [4:0] enter_mode;
  logic [1:0] acc_size;
  logic [1:0] acc_addr;
  logic [31:0] rd_a_data;
  logic [31:0] rd_b_data;
  logic [31:0] saved_data;
  logic [31:0] status_word;
  logic cond_pass;
  logic compact;
  logic [2:0] insn_bytes;
  logic misaligned;
  logic refused;
  logic privileged;
  modport datapath (
    output op, rd_a_idx, rd_b_idx, wr_idx, wr_data, hi_ok, is_branch, cond, enter_mode, acc_size, acc_addr,
    input rd_a_data, rd_b_data, saved_data, status_word, cond_pass, compact, insn_bytes, misaligned, refused,
    privileged
  );
  modport regfile (
    input op, rd_a_idx, rd_b_idx, wr_idx, wr_data, hi_ok, is_branch, cond, enter_mode, acc_size, acc_addr,
    output rd_a_data, rd_b_data, saved_data, status_word, cond_pass, compact, insn_bytes, misaligned, refused,
    privileged
  );
endinterface : rf_if

// file: core_datapath_end.sv
// Datapath end: turns Avalon-MM register writes into register file operations.
`include "rf_consts.svh"
module core_datapath_end (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Avalon-MM slave.
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Register file connection.
  rf_if.datapath rf
);
  import rf_pkg::*;

  dp_state_s st_r;
  dp_state_s st_nxt;
  logic access;
  logic [31:0] wr_merged;
  logic mode_ok;

  assign access = avs_read || avs_write;
  assign avs_waitrequest = access && !st_r.ack;
  assign avs_readdata = st_r.readdata;
  // The state bit is carried over from the live word so a control write cannot change it.
  assign wr_merged = {st_r.wdata[31:`SW_T + 1], rf.status_word[`SW_T], st_r.wdata[`SW_M_HI:0]};
  assign mode_ok = st_r.wdata[4:0] == `MODE_USR || st_r.wdata[4:0] == `MODE_FIQ ||
                   st_r.wdata[4:0] == `MODE_IRQ || st_r.wdata[4:0] == `MODE_SVC ||
                   st_r.wdata[4:0] == `MODE_UND || st_r.wdata[4:0] == `MODE_SYS;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = access && !st_r.ack;
    st_nxt.op = OP_NONE;
    st_nxt.issued = st_r.op != OP_NONE;
    if (st_r.op != OP_NONE) begin
      st_nxt.result = (st_r.op == OP_SAVED_RD) ? rf.saved_data : rf.rd_a_data;
      st_nxt.last = {rf.refused, rf.misaligned, rf.cond_pass, 1'b1};
    end
    if (access && !st_r.ack) begin
      case (avs_address)
        `OFS_WDATA: st_nxt.readdata = st_r.wdata;
        `OFS_RESULT: st_nxt.readdata = st_r.result;
        `OFS_FLAGS: st_nxt.readdata = {28'h0, st_r.last};
        `OFS_STATUS: st_nxt.readdata = rf.status_word;
        `OFS_CMD: st_nxt.readdata = st_r.cmd;
        default: st_nxt.readdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && st_r.ack) begin
      case (avs_address)
        `OFS_WDATA: st_nxt.wdata = avs_writedata;
        `OFS_CMD: begin
          st_nxt.cmd = avs_writedata;
          st_nxt.op = op_e'(avs_writedata[3:0]);
          st_nxt.wr_data = st_r.wdata;
          st_nxt.last = 4'h0;
          if (op_e'(avs_writedata[3:0]) == OP_CTRL) begin
            st_nxt.wr_data = wr_merged;
            if (!mode_ok) begin
              st_nxt.op = OP_NONE;
              st_nxt.last = 4'h9;
            end
          end
        end
        default: st_nxt.wdata = st_r.wdata;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rf.op = st_r.op;
  assign rf.rd_a_idx = st_r.cmd[7:4];
  assign rf.rd_b_idx = st_r.cmd[11:8];
  assign rf.wr_idx = st_r.cmd[7:4];
  assign rf.wr_data = st_r.wr_data;
  assign rf.hi_ok = st_r.cmd[12];
  assign rf.is_branch = st_r.cmd[13];
  assign rf.cond = st_r.cmd[17:14];
  assign rf.enter_mode = st_r.cmd[22:18];
  assign rf.acc_size = st_r.cmd[24:23];
  assign rf.acc_addr = st_r.cmd[26:25];
endmodule : core_datapath_end

// file: banked_register_file_psr_props.sv
// Assertions on the link between the datapath end and the banked register file.
`include "rf_consts.svh"
module banked_register_file_psr_props (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Requests from the datapath.
  input wire rf_pkg::op_e op,
  input wire logic [31:0] wr_data,
  input wire logic is_branch,
  input wire logic [4:0] enter_mode,
  input wire logic [1:0] acc_size,
  input wire logic [1:0] acc_addr,
  // Answers of the register file.
  input wire logic [31:0] status_word,
  input wire logic cond_pass,
  input wire logic compact,
  input wire logic [2:0] insn_bytes,
  input wire logic misaligned,
  input wire logic refused,
  input wire logic privileged,
  input wire logic irq_blocked,
  input wire logic fiq_blocked,
  input wire logic unrecoverable
);
  import rf_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence ctrl_go;
    op == OP_CTRL && !refused;
  endsequence
  sequence enter_go;
    op == OP_ENTER && !refused;
  endsequence
  insn_len_a: assert property (insn_bytes == (compact ? 3'h2 : 3'h4)) else $error("insn length");
  state_bit_a: assert property (compact == status_word[5]) else $error("state bit");
  mask_out_a: assert property ({irq_blocked, fiq_blocked} == status_word[7:6]) else $error("mask out");
  reset_word_a: assert property ($rose(arst_n) |-> status_word == 32'h000000D3) else $error("reset word");
  align_a: assert property (misaligned == ((acc_size == 2'h2 && acc_addr != 2'h0) ||
    (acc_size == 2'h1 && acc_addr[0]))) else $error("alignment");
  lock_keep_a: assert property (unrecoverable |=> unrecoverable) else $error("lock lost");
  priv_mode_a: assert property (!unrecoverable |-> privileged == (status_word[4:0] != `MODE_USR))
    else $error("privilege");
  user_ctrl_a: assert property (op == OP_CTRL && status_word[4:0] == `MODE_USR |-> refused)
    else $error("user control");
  ctrl_mode_a: assert property (ctrl_go |=> status_word[4:0] == $past(wr_data[4:0]))
    else $error("mode follow");
  no_abort_a: assert property (op == OP_ENTER && !(enter_mode inside {`MODE_FIQ, `MODE_IRQ, `MODE_SVC,
    `MODE_UND}) |-> refused) else $error("bad entry");
  enter_word_a: assert property (enter_go |=> status_word[7] && !status_word[5] &&
    status_word[4:0] == $past(enter_mode)) else $error("entry word");
  compact_cond_a: assert property (compact && op == OP_COND && !is_branch |-> cond_pass)
    else $error("compact cond");
endmodule : banked_register_file_psr_props

// file: banked_register_file_psr_tb.sv
// Self-checking bench for the datapath end and register file pair.
`include "rf_consts.svh"
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module banked_register_file_psr_tb import rf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_blocked;
  logic fiq_blocked;
  logic unrecoverable;
  logic [31:0] f;
  logic [31:0] r;
  int n_errors = 0;
  int tests_run = 0;
  always #50 mclk = ~mclk;
  rf_if link();
  core_datapath_end core_datapath_end_i (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rf(link));
  banked_register_file_psr banked_register_file_psr_i (.mclk(mclk), .arst_n(arst_n), .core(link),
    .irq_blocked(irq_blocked), .fiq_blocked(fiq_blocked), .unrecoverable(unrecoverable));
  banked_register_file_psr_props banked_register_file_psr_props_i (.mclk(mclk), .arst_n(arst_n), .op(link.op),
    .wr_data(link.wr_data), .is_branch(link.is_branch), .enter_mode(link.enter_mode), .acc_size(link.acc_size),
    .acc_addr(link.acc_addr), .status_word(link.status_word), .cond_pass(link.cond_pass), .compact(link.compact),
    .insn_bytes(link.insn_bytes), .misaligned(link.misaligned), .refused(link.refused),
    .privileged(link.privileged), .irq_blocked(irq_blocked), .fiq_blocked(fiq_blocked),
    .unrecoverable(unrecoverable));
  task automatic test_done();
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // One Avalon access; the request is held until waitrequest is sampled low.
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  function automatic logic [31:0] mk(op_e o, logic [3:0] a = 4'h0, logic [3:0] c = 4'h0, logic br = 1'b0,
    logic [4:0] em = 5'h00, logic [1:0] sz = 2'h0, logic [1:0] ad = 2'h0);
    return {5'h00, ad, sz, em, c, br, 1'b0, 4'h0, a, o};
  endfunction : mk
  // Issues one operation, then fetches its flags and result.
  task automatic op(input logic [31:0] c, input logic [31:0] w);
    av(1'b1, `OFS_WDATA, w, r);
    av(1'b1, `OFS_CMD, c, r);
    av(1'b0, `OFS_FLAGS, 32'h0, f);
    av(1'b0, `OFS_RESULT, 32'h0, r);
  endtask : op
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    test_done();
  end
  initial begin
    static logic [4:0] md [5] = '{`MODE_SVC, `MODE_IRQ, `MODE_UND, `MODE_SYS, `MODE_FIQ};
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    av(1'b0, `OFS_STATUS, 32'h0, r);
    `CHK("status", 32'h000000D3, r)
    `CHK("masks", 2'b11, {irq_blocked, fiq_blocked})
    for (int i = 0; i < 5; i++) begin
      op(mk(OP_CTRL), {27'h6, md[i]});
      op(mk(OP_WRITE, `STACK_IDX), 32'h100 | md[i]);
      op(mk(OP_WRITE, 4'h8), 32'h200 | md[i]);
    end
    for (int i = 0; i < 5; i++) begin
      op(mk(OP_CTRL), {27'h6, md[i]});
      op(mk(OP_READ, `STACK_IDX), 32'h0);
      `CHK("r13", 32'h100 | md[i], r)
      op(mk(OP_READ, 4'h8), 32'h0);
      `CHK("r8", (md[i] == `MODE_FIQ) ? 32'h211 : 32'h21F, r)
    end
    op(mk(OP_CTRL), 32'h10);
    op(mk(OP_READ, `STACK_IDX), 32'h0);
    `CHK("user r13", 32'h11F, r)
    `CHK("unmasked", 2'b00, {irq_blocked, fiq_blocked})
    op(mk(OP_CTRL), 32'h13);
    `CHK("user ctrl", 1'b1, f[3])
    op(mk(OP_CTRL), 32'h15);
    `CHK("bad mode", 32'h9, f)
    `CHK("no lock", 1'b0, unrecoverable)
    op(mk(OP_LINK), 32'h203);
    op(mk(OP_LINK), 32'h87);
    op(mk(OP_READ, `LINK_IDX), 32'h0);
    `CHK("link", 32'h200, r)
    op(mk(OP_READ, `PC_IDX), 32'h0);
    `CHK("pc", 32'h84, r)
    op(mk(OP_FLAGS), 32'hF0000000);
    op(mk(OP_COND), 32'h0);
    `CHK("eq", 1'b1, f[1])
    op(mk(OP_COND, 4'h0, 4'h1), 32'h0);
    `CHK("ne", 1'b0, f[1])
    op(mk(OP_ENTER, 4'h0, 4'h0, 1'b0, `MODE_IRQ), 32'h40);
    av(1'b0, `OFS_STATUS, 32'h0, r);
    `CHK("enter", 32'hF0000092, r)
    op(mk(OP_SAVED_RD), 32'h0);
    `CHK("saved", 32'hF0000010, r)
    op(mk(OP_READ, `LINK_IDX), 32'h0);
    `CHK("irq r14", 32'h40, r)
    op(mk(OP_ENTER, 4'h0, 4'h0, 1'b0, 5'h17), 32'h0);
    `CHK("abort", 1'b1, f[3])
    op(mk(OP_SAVED_WR), 32'h30);
    op(mk(OP_RETURN), 32'h203);
    av(1'b0, `OFS_STATUS, 32'h0, r);
    `CHK("return", 32'h30, r)
    `CHK("len", `LEN_COMPACT, link.insn_bytes)
    op(mk(OP_COND), 32'h0);
    `CHK("c plain", 1'b1, f[1])
    op(mk(OP_COND, 4'h0, 4'h0, 1'b1), 32'h0);
    `CHK("c branch", 1'b0, f[1])
    op(mk(OP_READ, `STACK_IDX), 32'h0);
    `CHK("c r13", 32'h11F, r)
    op(mk(OP_READ, 4'h8), 32'h0);
    `CHK("c r8 hidden", 32'h0, r)
    op(mk(OP_READ, 4'h0, 4'h0, 1'b0, 5'h00, `ACC_WORD, 2'h2), 32'h0);
    `CHK("misalign", 1'b1, f[2])
    op(mk(OP_WRITE, 4'h9), 32'h5);
    `CHK("hi write", 1'b1, f[3])
    op(mk(OP_ENTER, 4'h0, 4'h0, 1'b0, `MODE_SVC), 32'h0);
    op(mk(OP_SAVED_WR), 32'h15);
    op(mk(OP_RETURN), 32'h0);
    `CHK("locked", 1'b1, unrecoverable)
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    av(1'b0, `OFS_STATUS, 32'h0, r);
    `CHK("status2", 32'h000000D3, r)
    `CHK("unlocked", 1'b0, unrecoverable)
    test_done();
  end
endmodule : banked_register_file_psr_tb
